// ==== common/aesx_map.vh ====
/*
 * Register map, field positions, reset values and timing counts of the AES engine.
 * Assumes inclusion by the design, checker and bench files; holds definitions only.
 */
`ifndef AESX_MAP_VH
`define AESX_MAP_VH

`define AESX_ADDR_W 8
`define AESX_ADDR_CTRL 8'h00
`define AESX_ADDR_STATUS 8'h01
`define AESX_ADDR_KEY 8'h02
`define AESX_ADDR_STATE 8'h03

`define AESX_CTRL_IRQ_EN_BIT 2
`define AESX_CTRL_DIR_BIT 3
`define AESX_CTRL_MODE_BIT 5
`define AESX_CTRL_REQUEST_BIT 7
`define AESX_STATUS_DONE_BIT 0
`define AESX_STATUS_ERROR_BIT 7

`define AESX_CTRL_RESET 8'h00
`define AESX_STATUS_RESET 8'h00

`define AESX_CLK_PERIOD_NS 8
`define AESX_OP_TIME_NS 24000
`define AESX_OP_CYC (`AESX_OP_TIME_NS / `AESX_CLK_PERIOD_NS)
`define AESX_CNT_W 12

`define AESX_RCON_FIRST 8'h01
`define AESX_RCON_LAST 8'h36
`define AESX_ROUNDS 4'hA

`endif

// ==== design/aesx_sbox.v ====
/*
 * One byte substitution of the AES cipher, forward or inverse, computed from the
 * field inverse instead of a table. Assumes a purely combinational use.
 */
`timescale 1ns/100ps
module aesx_sbox (
    input wire [7:0] din,
    input wire inv,
    output wire [7:0] dout
);

    function [7:0] gmul;
        input [7:0] a;
        input [7:0] b;
        reg [7:0] p;
        reg [7:0] aa;
        integer k;
        begin
            p = 8'h00;
            aa = a;
            for (k = 0; k < 8; k = k + 1) begin
                if (b[k]) begin
                    p = p ^ aa;
                end
                aa = {aa[6:0], 1'b0} ^ (aa[7] ? 8'h1B : 8'h00);
            end
            gmul = p;
        end
    endfunction

    // Raising to the power 254 yields the inverse and maps zero onto zero.
    function [7:0] ginv;
        input [7:0] x;
        reg [7:0] p;
        reg [7:0] r;
        integer k;
        begin
            p = x;
            r = 8'h01;
            for (k = 1; k < 8; k = k + 1) begin
                p = gmul(p, p);
                r = gmul(r, p);
            end
            ginv = r;
        end
    endfunction

    function [7:0] rotl;
        input [7:0] x;
        input integer n;
        begin
            rotl = (x << n) | (x >> (8 - n));
        end
    endfunction

    wire [7:0] fwd_inv;
    wire [7:0] inv_aff;

    assign fwd_inv = ginv(din);
    assign inv_aff = rotl(din, 1) ^ rotl(din, 3) ^ rotl(din, 6) ^ 8'h05;
    assign dout = inv ? ginv(inv_aff)
        : (fwd_inv ^ rotl(fwd_inv, 1) ^ rotl(fwd_inv, 2) ^ rotl(fwd_inv, 3)
           ^ rotl(fwd_inv, 4) ^ 8'h63);

endmodule

// ==== design/aesx_core.v ====
/*
 * Iterative AES-128 round engine, one round per clock. Encryption expands the key
 * forward from the loaded key; decryption starts from the last round key and runs
 * the schedule backwards. Assumes start only while busy is low.
 */
`timescale 1ns/100ps
`include "aesx_map.vh"
module aesx_core (
    input wire sys_clk,
    input wire arst_n,
    input wire clr,
    input wire start,
    input wire decrypt,
    input wire [127:0] din,
    input wire [127:0] key_in,
    output wire [127:0] dout,
    output wire [127:0] kout,
    output wire busy
);

    reg [127:0] st_r;
    reg [127:0] key_r;
    reg [3:0] rnd_r;
    reg [7:0] rcon_r;
    reg dec_r;
    reg busy_r;

    function [7:0] xt;
        input [7:0] a;
        begin
            xt = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
        end
    endfunction

    function [7:0] gm;
        input [7:0] a;
        input [3:0] b;
        begin
            gm = (b[0] ? a : 8'h00) ^ (b[1] ? xt(a) : 8'h00)
                ^ (b[2] ? xt(xt(a)) : 8'h00) ^ (b[3] ? xt(xt(xt(a))) : 8'h00);
        end
    endfunction

    function [31:0] mixc;
        input [31:0] c;
        input inv;
        reg [7:0] a0;
        reg [7:0] a1;
        reg [7:0] a2;
        reg [7:0] a3;
        reg [3:0] e;
        reg [3:0] b;
        reg [3:0] d;
        reg [3:0] n;
        begin
            a0 = c[31:24];
            a1 = c[23:16];
            a2 = c[15:8];
            a3 = c[7:0];
            e = inv ? 4'hE : 4'h2;
            b = inv ? 4'hB : 4'h3;
            d = inv ? 4'hD : 4'h1;
            n = inv ? 4'h9 : 4'h1;
            mixc = {gm(a0, e) ^ gm(a1, b) ^ gm(a2, d) ^ gm(a3, n),
                    gm(a0, n) ^ gm(a1, e) ^ gm(a2, b) ^ gm(a3, d),
                    gm(a0, d) ^ gm(a1, n) ^ gm(a2, e) ^ gm(a3, b),
                    gm(a0, b) ^ gm(a1, d) ^ gm(a2, n) ^ gm(a3, e)};
        end
    endfunction

    wire [127:0] sb_in;
    wire [127:0] sub;
    wire [127:0] rk;
    wire [127:0] pre;
    wire [127:0] mixed;
    wire [31:0] w0;
    wire [31:0] w1;
    wire [31:0] w2;
    wire [31:0] w3;
    wire [31:0] sw_in;
    wire [31:0] sw_out;
    wire [31:0] t;
    wire [31:0] n0;
    wire [31:0] n1;
    wire [31:0] n2;
    wire last;

    assign {w0, w1, w2, w3} = key_r;
    assign n0 = w0 ^ t;
    assign n1 = w1 ^ n0;
    assign n2 = w2 ^ n1;
    assign sw_in = dec_r ? (w3 ^ w2) : w3;
    assign t = {sw_out[23:0], sw_out[31:24]} ^ {rcon_r, 24'h000000};
    assign rk = dec_r ? {w0 ^ t, w1 ^ w0, w2 ^ w1, w3 ^ w2} : {n0, n1, n2, w3 ^ n2};
    assign last = (rnd_r == `AESX_ROUNDS);
    assign pre = dec_r ? (sub ^ rk) : sub;

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_byte
            localparam integer R = i % 4;
            localparam integer C = i / 4;
            localparam integer FS = 4 * ((C + R) % 4) + R;
            localparam integer IS = 4 * ((C + 4 - R) % 4) + R;
            assign sb_in[127 - 8 * i -: 8] = dec_r ? st_r[127 - 8 * IS -: 8]
                : st_r[127 - 8 * FS -: 8];
            aesx_sbox u_sb (
                .din(sb_in[127 - 8 * i -: 8]),
                .inv(dec_r),
                .dout(sub[127 - 8 * i -: 8])
            );
        end
        for (i = 0; i < 4; i = i + 1) begin : g_col
            assign mixed[127 - 32 * i -: 32] = mixc(pre[127 - 32 * i -: 32], dec_r);
            aesx_sbox u_ksb (
                .din(sw_in[31 - 8 * i -: 8]),
                .inv(1'b0),
                .dout(sw_out[31 - 8 * i -: 8])
            );
        end
    endgenerate

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= 128'h0;
            key_r <= 128'h0;
            rnd_r <= 4'h0;
            rcon_r <= 8'h00;
            dec_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (clr) begin
            st_r <= 128'h0;
            key_r <= 128'h0;
            rnd_r <= 4'h0;
            rcon_r <= 8'h00;
            dec_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (start) begin
            // Either direction whitens with the loaded key: round 0 or round 10.
            st_r <= din ^ key_in;
            key_r <= key_in;
            rnd_r <= 4'h1;
            rcon_r <= decrypt ? `AESX_RCON_LAST : `AESX_RCON_FIRST;
            dec_r <= decrypt;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            if (dec_r) begin
                st_r <= last ? pre : mixed;
                rcon_r <= rcon_r[0] ? ((rcon_r ^ 8'h1B) >> 1) | 8'h80 : rcon_r >> 1;
            end else begin
                st_r <= (last ? sub : mixed) ^ rk;
                rcon_r <= xt(rcon_r);
            end
            key_r <= rk;
            rnd_r <= rnd_r + 4'h1;
            busy_r <= !last;
        end
    end

    assign dout = st_r;
    assign kout = key_r;
    assign busy = busy_r;

endmodule

// ==== design/aesx_engine.v ====
/*
 * AES-128 engine with ECB encryption and decryption and CBC encryption, reached
 * through byte-serial key and data ports plus control and status registers.
 * Assumes a register master on sys_clk, and radio sleep and reset levels that
 * arrive from another domain and are synchronised here.
 */
// Our own choices: the strobed register port and the address map.
// Summary of operation
// - One byte pointer serves both buffers and advances on each access.
// - Every run returns the byte pointer to zero.
// - A partially transferred key or data block makes the next run fail.
// - Mode bit zero selects ECB, one selects CBC.
// - Direction bit picks encrypt or decrypt; CBC requires encrypt.
// - Writing one to the request bit starts a run.
// - A run takes 24 us, then sets done and raises the interrupt.
// - The result reads back as sixteen data bytes from byte zero.
// - No register access is accepted during radio sleep.
// - Radio sleep or reset clears configuration, buffers and keys.
// - Key reads after a run return that run's final round key.
// - The written key stays intact and is reused by the next run.
// - A control read resets the byte pointer.
// - The pointer is zero after radio reset and after a run.
// - CBC XORs new input with the previous result, then encrypts.
// - At completion error is set on failure, else done reads one.
// - A status read clears the error flag.
// - Any data buffer access clears the done flag.
// - No new interrupt until both flags clear, none while disabled.
`timescale 1ns/100ps
`include "aesx_map.vh"
module aesx_engine (
    input wire sys_clk,
    input wire arst_n,
    input wire [`AESX_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    input wire trx_sleep,
    input wire trx_reset,
    output wire ready_irq
);

    localparam integer OP_LAST_I = `AESX_OP_CYC - 1;
    localparam [`AESX_CNT_W-1:0] OP_LAST = OP_LAST_I[`AESX_CNT_W-1:0];

    reg sleep_m_r;
    reg sleep_s_r;
    reg trst_m_r;
    reg trst_s_r;
    reg [127:0] key_r;
    reg [127:0] rkey_r;
    reg [127:0] state_r;
    reg [127:0] chain_r;
    reg [3:0] ptr_r;
    reg key_ok_r;
    reg data_ok_r;
    reg mode_r;
    reg dir_r;
    reg ready_irq_enable_r;
    reg busy_r;
    reg err_pend_r;
    reg [`AESX_CNT_W-1:0] cnt_r;
    reg done_r;
    reg error_flag_r;
    reg irq_r;
    reg [7:0] rdata_r;
    reg [7:0] rdata_nxt;

    wire clr;
    wire acc_ok;
    wire wr_ok;
    wire rd_ok;
    wire key_acc;
    wire data_acc;
    wire buf_acc;
    wire start_req;
    wire run_ok;
    wire complete;
    wire core_dec;
    wire [127:0] core_din;
    wire [127:0] core_dout;
    wire [127:0] core_kout;
    wire [7:0] key_byte;
    wire [7:0] data_byte;

    // Two stages each, since the radio levels come from the radio's domain.
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_m_r <= 1'b0;
            sleep_s_r <= 1'b0;
            trst_m_r <= 1'b0;
            trst_s_r <= 1'b0;
        end else begin
            sleep_m_r <= trx_sleep;
            sleep_s_r <= sleep_m_r;
            trst_m_r <= trx_reset;
            trst_s_r <= trst_m_r;
        end
    end

    assign clr = sleep_s_r | trst_s_r;
    assign acc_ok = !sleep_s_r;
    assign wr_ok = acc_ok && reg_wr;
    assign rd_ok = acc_ok && reg_rd;
    // Buffer traffic is ignored while a run is in flight, so a result cannot tear.
    assign key_acc = (wr_ok || rd_ok) && !busy_r && (reg_addr == `AESX_ADDR_KEY);
    assign data_acc = (wr_ok || rd_ok) && !busy_r && (reg_addr == `AESX_ADDR_STATE);
    assign buf_acc = key_acc || data_acc;
    assign start_req = wr_ok && !busy_r && (reg_addr == `AESX_ADDR_CTRL)
        && reg_wdata[`AESX_CTRL_REQUEST_BIT];
    assign run_ok = (ptr_r == 4'h0) && key_ok_r && data_ok_r;
    assign complete = busy_r && (cnt_r == OP_LAST);

    assign core_dec = reg_wdata[`AESX_CTRL_DIR_BIT] && !reg_wdata[`AESX_CTRL_MODE_BIT];
    assign core_din = reg_wdata[`AESX_CTRL_MODE_BIT] ? (state_r ^ chain_r) : state_r;

    aesx_core u_core (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clr(clr),
        .start(start_req && run_ok && !clr),
        .decrypt(core_dec),
        .din(core_din),
        .key_in(key_r),
        .dout(core_dout),
        .kout(core_kout),
        .busy()
    );

    assign key_byte = rkey_r[8 * (15 - ptr_r) +: 8];
    assign data_byte = state_r[8 * (15 - ptr_r) +: 8];

    always @* begin
        rdata_nxt = 8'h00;
        if (rd_ok) begin
            case (reg_addr)
                `AESX_ADDR_CTRL: begin
                    rdata_nxt[`AESX_CTRL_MODE_BIT] = mode_r;
                    rdata_nxt[`AESX_CTRL_DIR_BIT] = dir_r;
                    rdata_nxt[`AESX_CTRL_IRQ_EN_BIT] = ready_irq_enable_r;
                end
                `AESX_ADDR_STATUS: begin
                    rdata_nxt[`AESX_STATUS_DONE_BIT] = done_r;
                    rdata_nxt[`AESX_STATUS_ERROR_BIT] = error_flag_r;
                end
                `AESX_ADDR_KEY: begin
                    rdata_nxt = busy_r ? 8'h00 : key_byte;
                end
                `AESX_ADDR_STATE: begin
                    rdata_nxt = busy_r ? 8'h00 : data_byte;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            key_r <= 128'h0;
            rkey_r <= 128'h0;
            state_r <= 128'h0;
            chain_r <= 128'h0;
            ptr_r <= 4'h0;
            key_ok_r <= 1'b0;
            data_ok_r <= 1'b0;
            mode_r <= 1'b0;
            dir_r <= 1'b0;
            ready_irq_enable_r <= 1'b0;
            busy_r <= 1'b0;
            err_pend_r <= 1'b0;
            cnt_r <= {`AESX_CNT_W{1'b0}};
            done_r <= 1'b0;
            error_flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (clr) begin
            key_r <= 128'h0;
            rkey_r <= 128'h0;
            state_r <= 128'h0;
            chain_r <= 128'h0;
            ptr_r <= 4'h0;
            key_ok_r <= 1'b0;
            data_ok_r <= 1'b0;
            mode_r <= 1'b0;
            dir_r <= 1'b0;
            ready_irq_enable_r <= 1'b0;
            busy_r <= 1'b0;
            err_pend_r <= 1'b0;
            cnt_r <= {`AESX_CNT_W{1'b0}};
            done_r <= 1'b0;
            error_flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            irq_r <= 1'b0;
            if (buf_acc) begin
                ptr_r <= ptr_r + 4'h1;
            end
            if (key_acc && wr_ok) begin
                key_r[8 * (15 - ptr_r) +: 8] <= reg_wdata;
                if (ptr_r == 4'hF) begin
                    key_ok_r <= 1'b1;
                end
            end
            if (data_acc && wr_ok) begin
                state_r[8 * (15 - ptr_r) +: 8] <= reg_wdata;
            end
            if (data_acc && ptr_r == 4'hF) begin
                data_ok_r <= 1'b1;
            end
            if (data_acc) begin
                done_r <= 1'b0;
            end
            if (rd_ok && reg_addr == `AESX_ADDR_STATUS) begin
                error_flag_r <= 1'b0;
            end
            if (rd_ok && reg_addr == `AESX_ADDR_CTRL) begin
                ptr_r <= 4'h0;
            end
            if (wr_ok && reg_addr == `AESX_ADDR_CTRL) begin
                mode_r <= reg_wdata[`AESX_CTRL_MODE_BIT];
                dir_r <= reg_wdata[`AESX_CTRL_DIR_BIT];
                ready_irq_enable_r <= reg_wdata[`AESX_CTRL_IRQ_EN_BIT];
            end
            if (start_req) begin
                busy_r <= 1'b1;
                err_pend_r <= !run_ok;
                cnt_r <= {`AESX_CNT_W{1'b0}};
                ptr_r <= 4'h0;
                data_ok_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r + {{(`AESX_CNT_W-1){1'b0}}, 1'b1};
            end
            // Completion sets flags after the clears above, so a set wins.
            if (complete) begin
                busy_r <= 1'b0;
                ptr_r <= 4'h0;
                if (err_pend_r) begin
                    error_flag_r <= 1'b1;
                end else begin
                    done_r <= 1'b1;
                    state_r <= core_dout;
                    chain_r <= core_dout;
                    rkey_r <= core_kout;
                end
                irq_r <= ready_irq_enable_r && !done_r && !error_flag_r;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign ready_irq = irq_r;

endmodule

// ==== testbench/aesx_engine_properties.sv ====
/* Checker of the AES engine register port and ready interrupt.
   Assumes it is bound to aesx_engine and that runs start only while idle. */
`timescale 1ns/100ps
`include "aesx_map.vh"
module aesx_props (
    input wire sys_clk,
    input wire arst_n,
    input wire [`AESX_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire trx_sleep,
    input wire trx_reset,
    input wire ready_irq
);
    // Cycles since the accepted start; the run has ended once it reaches OP_CYC + 1.
    reg [12:0] run_cnt_r;
    wire idle = (run_cnt_r == 13'h0000) || (run_cnt_r == `AESX_OP_CYC + 1);
    wire go = reg_wr && (reg_addr == `AESX_ADDR_CTRL) && reg_wdata[`AESX_CTRL_REQUEST_BIT];
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_cnt_r <= 13'h0000;
        end else if (trx_sleep || trx_reset) begin
            run_cnt_r <= 13'h0000;
        end else if (go && idle) begin
            run_cnt_r <= 13'h0001;
        end else if (!idle) begin
            run_cnt_r <= run_cnt_r + 13'h0001;
        end else begin
            run_cnt_r <= 13'h0000;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_stat_rd;
        reg_rd && (reg_addr == `AESX_ADDR_STATUS) && (run_cnt_r == 13'h0000);
    endsequence
    sequence s_data_acc;
        (reg_rd || reg_wr) && (reg_addr == `AESX_ADDR_STATE) && (run_cnt_r == 13'h0000);
    endsequence
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_irq_one_cycle: assert property (ready_irq |=> !ready_irq)
        else $error("ready interrupt longer than one cycle");
    a_irq_run_time: assert property (ready_irq |-> run_cnt_r == `AESX_OP_CYC + 1)
        else $error("ready interrupt not at end of run");
    a_ctrl_req_zero: assert property (reg_rd && reg_addr == `AESX_ADDR_CTRL |=> !reg_rdata[7])
        else $error("request bit reads back as one");
    a_status_reserved: assert property (s_stat_rd |=> reg_rdata[6:1] == 6'h00)
        else $error("status reserved bits not zero");
    a_error_read_clear: assert property (s_stat_rd ##2 s_stat_rd |=> !reg_rdata[7])
        else $error("error flag survived a status read");
    a_done_access_clear: assert property (s_data_acc ##2 s_stat_rd |=> !reg_rdata[0])
        else $error("done flag survived a data access");
    a_busy_buffer_zero: assert property (reg_rd && (reg_addr == `AESX_ADDR_STATE)
        && (run_cnt_r > 13'h0000) && (run_cnt_r < 13'h0BB8) |=> reg_rdata == 8'h00)
        else $error("buffer read during run not refused");
    a_sleep_read_zero: assert property (trx_sleep [*3] ##0 reg_rd |=> reg_rdata == 8'h00)
        else $error("register read answered during sleep");
    a_sleep_no_irq: assert property (trx_sleep [*4] |-> !ready_irq)
        else $error("ready interrupt during sleep");
endmodule
bind aesx_engine aesx_props u_props (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .trx_sleep(trx_sleep),
    .trx_reset(trx_reset),
    .ready_irq(ready_irq)
);

// ==== testbench/aesx_engine_bench.sv ====
/* Self-checking bench of the AES engine through its register port.
   Assumes a run of 3000 cycles and byte 0 as the most significant byte. */
`timescale 1ns/100ps
`include "aesx_map.vh"
module aesx_engine_bench;
    localparam [7:0] CTL = `AESX_ADDR_CTRL;
    localparam [7:0] STA = `AESX_ADDR_STATUS;
    localparam [7:0] KEY = `AESX_ADDR_KEY;
    localparam [7:0] DAT = `AESX_ADDR_STATE;
    localparam [127:0] K0 = 128'h000102030405060708090A0B0C0D0E0F;
    localparam [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
    localparam [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam [127:0] RK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic trx_sleep = 1'b0;
    logic trx_reset = 1'b0;
    wire [7:0] reg_rdata;
    wire ready_irq;
    integer n_fail = 0;
    integer samples_checked = 0;
    logic [7:0] irq_seen = 8'h00;
    integer i;
    aesx_engine uut (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .trx_sleep(trx_sleep),
        .trx_reset(trx_reset),
        .ready_irq(ready_irq)
    );
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (ready_irq === 1'b1) irq_seen <= irq_seen + 8'h01;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task wr16(input logic [7:0] a, input logic [127:0] v);
        for (i = 0; i < 16; i = i + 1) wr(a, v[127-8*i -: 8]);
    endtask
    task rd16(input logic [7:0] a, input logic [127:0] v);
        for (i = 0; i < 16; i = i + 1) rd(a, v[127-8*i -: 8]);
    endtask
    // The wait is the fixed run length, so flags are looked at just after they land.
    task run(input logic [7:0] c);
        wr(CTL, c);
        repeat (`AESX_OP_CYC) @(posedge sys_clk);
    endtask
    task pulse(input logic slp);
        @(posedge sys_clk);
        trx_sleep <= slp;
        trx_reset <= !slp;
        repeat (3) @(posedge sys_clk);
        if (slp) rd(STA, 8'h00);
        if (slp) rd(DAT, 8'h00);
        @(posedge sys_clk);
        trx_sleep <= 1'b0;
        trx_reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task give_verdict;
        $display("compared %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail = n_fail + 1;
        give_verdict;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(CTL, `AESX_CTRL_RESET);
        rd(8'h0F, 8'h00);
        wr16(DAT, PT);
        run(8'h80);
        rd(STA, 8'h80);
        rd(STA, 8'h00);
        $display("test 1 done");
        wr16(KEY, K0);
        wr(CTL, 8'h04);
        wr16(DAT, PT);
        wr(CTL, 8'h84);
        rd(DAT, 8'h00);
        repeat (`AESX_OP_CYC) @(posedge sys_clk);
        chk(irq_seen, 8'h01);
        rd(STA, 8'h01);
        rd(CTL, 8'h04);
        rd16(DAT, CT);
        rd(STA, 8'h00);
        rd16(KEY, RK);
        $display("test 2 done");
        for (i = 0; i < 5; i = i + 1) wr(DAT, 8'hAA);
        rd(CTL, 8'h04);
        wr16(DAT, PT);
        run(8'h84);
        rd(STA, 8'h01);
        chk(irq_seen, 8'h02);
        run(8'h84);
        rd(STA, 8'h81);
        chk(irq_seen, 8'h02);
        rd16(DAT, CT);
        $display("test 3 done");
        wr(DAT, CT[127:120]);
        wr(DAT, CT[119:112]);
        wr(DAT, CT[111:104]);
        run(8'h80);
        rd(STA, 8'h80);
        chk(irq_seen, 8'h02);
        rd(STA, 8'h00);
        rd16(DAT, CT);
        $display("test 4 done");
        wr16(DAT, CT ^ PT);
        run(8'hA0);
        rd(STA, 8'h01);
        rd16(DAT, CT);
        $display("test 5 done");
        wr16(KEY, RK);
        wr16(DAT, CT);
        run(8'h88);
        rd(STA, 8'h01);
        rd16(DAT, PT);
        rd16(KEY, K0);
        rd(CTL, 8'h08);
        $display("test 6 done");
        pulse(1'b1);
        rd(CTL, 8'h00);
        wr16(DAT, PT);
        run(8'h80);
        rd(STA, 8'h80);
        $display("test 7 done");
        wr16(KEY, K0);
        wr(DAT, 8'h55);
        pulse(1'b0);
        wr16(KEY, K0);
        wr16(DAT, PT);
        run(8'h80);
        rd(STA, 8'h01);
        rd16(DAT, CT);
        $display("test 8 done");
        give_verdict;
    end
endmodule
